// File: core/dsl_pkg.sv
`default_nettype none
// ----------------------------------------
// shared constants and types
// ----------------------------------------
package dsl_pkg;

  localparam int DSL_DATA_W          = 8;     // character width
  localparam int DSL_BAUD_W          = 16;    // bit time counter width
  localparam int DSL_FIFO_DEPTH      = 4;     // transmit queue depth
  localparam int DSL_BREAK_TX_CYCLES = 4096;  // length of returned break
  localparam int DSL_SYNC_SHIFT      = 3;     // sync char is low for 8 bits

  localparam logic [3:0] DSL_BIT_START = 4'h0;  // start bit index
  localparam logic [3:0] DSL_BIT_STOP  = 4'h9;  // stop bit index
  localparam logic [3:0] DSL_BRK_BITS  = 4'hA;  // low bits that make a break

  // line drive options
  typedef struct packed {
    logic drive_both;             // drive high and low while sending
    logic tx_drive_high_assist;   // help rising edges only
  } dsl_cfg_type;

  // error events
  typedef struct packed {
    logic brk;  // line held low too long
    logic frm;  // stop bit seen low
    logic col;  // host talked over us
  } dsl_err_type;

  // link states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BAUD,
    ST_RX,
    ST_TX,
    ST_BREAK
  } dsl_state_type;

endpackage
`default_nettype wire

// File: core/dsl_fifo.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// small synchronous fifo
// ----------------------------------------
module dsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             ce_in,
  input  wire logic             flush_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];  // storage, no reset needed
  logic [AW-1:0]    wr_ptr_reg;       // next slot to write
  logic [AW-1:0]    rd_ptr_reg;       // oldest entry
  logic [CW-1:0]    count_reg;        // entries held
  logic [CW-1:0]    count_next;
  logic             ready_reg;        // not full, registered so ready is a flop
  wire              push = in_valid_in && ready_reg;
  wire              pop  = out_valid_out && out_ready_in;
  wire [AW-1:0]     wr_ptr_inc = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1'h1);
  wire [AW-1:0]     rd_ptr_inc = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1'h1);

  assign in_ready_out  = ready_reg;
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];

  // occupancy after this cycle
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + CW'(1'h1);
    end else if (pop && !push) begin
      count_next = count_reg - CW'(1'h1);
    end
  end

  // pointers and count; flush drops everything queued
  always_ff @(posedge clk_in) begin
    if (reset_in || (ce_in && flush_in)) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      ready_reg  <= 1'h1;
    end else if (ce_in) begin
      if (push) wr_ptr_reg <= wr_ptr_inc;
      if (pop) rd_ptr_reg <= rd_ptr_inc;
      count_reg <= count_next;
      ready_reg <= (count_next != CW'(DEPTH));
    end
  end

  // data store
  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

endmodule
`default_nettype wire

// File: core/dsl_link.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R01: flag break after ten low bit times
// R02: flag framing error on low stop bit
// R03: flag collision when host overlaps our send
// R04: any error aborts the running command
// R05: answer errors with 4096-cycle low break
// R06: error recovery clears the baud detector
// R07: host may force recovery with a break
// R08: drive-both drives line high and low
// R09: drive from start bit to stop midpoint
// R10: assist drives high until high or centre
// R11: both set: one-clock high on rising edge
// R12: an unlocked link autobauds on the host sync char
// R13: baud generator runs at measured host rate
// R14: break length uses the measured bit time
module dsl_link #(
  parameter int BAUD_W          = dsl_pkg::DSL_BAUD_W,
  parameter int FIFO_DEPTH      = dsl_pkg::DSL_FIFO_DEPTH,
  parameter int BREAK_TX_CYCLES = dsl_pkg::DSL_BREAK_TX_CYCLES
) (
  input  wire logic                         clk_in,
  input  wire logic                         reset_in,
  input  wire logic                         ce_in,
  input  wire logic                         debug_serial_pin_in,
  output logic                              debug_serial_pin_out,
  output logic                              debug_serial_pin_oe_out,
  input  wire dsl_pkg::dsl_cfg_type         cfg_in,
  input  wire logic [dsl_pkg::DSL_DATA_W-1:0] tx_data_in,
  input  wire logic                         tx_valid_in,
  output logic                              tx_ready_out,
  output logic      [dsl_pkg::DSL_DATA_W-1:0] rx_data_out,
  output logic                              rx_valid_out,
  output dsl_pkg::dsl_err_type              err_out,
  output logic                              cmd_abort_out,
  output logic                              baud_locked_out
);
  import dsl_pkg::*;

  localparam int MW    = BAUD_W + DSL_SYNC_SHIFT;        // sync measure width
  localparam int LW    = BAUD_W + 4;                     // low run width
  localparam int BRK_W = $clog2(BREAK_TX_CYCLES + 1);    // break timer width

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic                  pin_s1_reg;        // first sync stage, read only by second
  logic                  pin_s2_reg;        // synchronised line level
  logic                  pin_s3_reg;        // previous level for edges
  dsl_state_type         state_reg;         // link state
  dsl_state_type         state_next;
  logic [BAUD_W-1:0]     bit_time_reg;      // cycles per bit
  logic                  baud_locked_reg;   // rate known
  logic [MW-1:0]         meas_cnt_reg;      // low cycles of sync char
  logic [BAUD_W-1:0]     bit_cnt_reg;       // cycle within bit
  logic [3:0]            bit_idx_reg;       // bit within frame
  logic [DSL_DATA_W-1:0] rx_shift_reg;      // receive shifter
  logic [DSL_DATA_W+1:0] tx_frame_reg;      // stop, data, start
  logic                  prev_bit_reg;      // last bit sent
  logic                  hi_done_reg;       // assist finished for this bit
  logic [LW-1:0]         low_cnt_reg;       // consecutive low cycles
  logic [BRK_W-1:0]      brk_cnt_reg;       // returned break timer
  logic                  pin_out_reg;       // pin value
  logic                  pin_oe_reg;        // pin enable
  logic [DSL_DATA_W-1:0] rx_data_reg;       // last good char
  logic                  rx_valid_reg;      // one-cycle strobe
  dsl_err_type           err_reg;           // one-cycle error strobes
  logic                  abort_reg;         // one-cycle abort
  logic                  drv_oe;            // drive decision
  logic                  drv_val;
  logic [DSL_DATA_W-1:0] fifo_data;         // head of send queue
  logic                  fifo_valid;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire              line_high     = pin_s2_reg;
  wire              line_fall     = pin_s3_reg && !pin_s2_reg;
  wire              line_rise     = !pin_s3_reg && pin_s2_reg;
  wire [BAUD_W-1:0] half_time     = bit_time_reg >> 1;
  wire              at_center     = (bit_cnt_reg == half_time);
  wire              before_center = (bit_cnt_reg < half_time);
  wire              at_end        = (bit_cnt_reg == bit_time_reg - BAUD_W'(1'h1));
  wire              tx_bit        = tx_frame_reg[bit_idx_reg];
  wire              at_stop       = (bit_idx_reg == DSL_BIT_STOP);
  wire              at_start      = (bit_idx_reg == DSL_BIT_START);
  wire [BAUD_W-1:0] meas_bits     = meas_cnt_reg[MW-1:DSL_SYNC_SHIFT];
  wire              meas_ovf      = &meas_cnt_reg;
  wire              in_rx         = (state_reg == ST_RX);
  wire              in_tx         = (state_reg == ST_TX);
  wire              assist_pulse  = cfg_in.drive_both && cfg_in.tx_drive_high_assist;
  // break threshold scales with the measured rate
  wire [LW-1:0]     brk_limit     = {4'h0, bit_time_reg} * {{BAUD_W{1'h0}}, DSL_BRK_BITS};  // R14
  wire              brk_last      = (brk_cnt_reg == BRK_W'(BREAK_TX_CYCLES - 1));
  wire              det_brk       = baud_locked_reg && !line_high
                                    && (low_cnt_reg == brk_limit - LW'(1'h1));  // R01
  wire              det_frm       = in_rx && at_stop && at_center && !line_high;  // R02
  wire              det_col       = in_tx && tx_bit && at_center && !line_high;  // R03
  wire              err_any       = det_brk || det_frm || det_col;
  wire              tx_pop        = (state_reg == ST_IDLE) && (state_next == ST_TX);

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_s1_reg <= 1'h1;
      pin_s2_reg <= 1'h1;
      pin_s3_reg <= 1'h1;
    end else if (ce_in) begin
      pin_s1_reg <= debug_serial_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // ----------------------------------------
  // link state machine
  // ----------------------------------------
  // half duplex: receive, send and sync measure never overlap
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (line_fall) begin
          // an unlocked link treats any start edge as a sync char
          state_next = baud_locked_reg ? ST_RX : ST_BAUD;  // R12
        end else if (baud_locked_reg && fifo_valid && line_high) begin
          state_next = ST_TX;
        end
      end
      ST_BAUD: begin
        if (line_rise || meas_ovf) state_next = ST_IDLE;
      end
      ST_RX: begin
        // false start or end of char at the stop centre
        if (at_center && ((at_start && line_high) || at_stop)) state_next = ST_IDLE;
      end
      ST_TX: begin
        if (at_stop && at_end) state_next = ST_IDLE;
      end
      ST_BREAK: begin
        if (brk_last) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (err_any) state_next = ST_BREAK;  // R04
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) state_reg <= ST_IDLE;
    else if (ce_in) state_reg <= state_next;
  end

  // ----------------------------------------
  // auto-baud
  // ----------------------------------------
  // the sync char is low for eight bit times, so divide by eight
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meas_cnt_reg    <= MW'(1'h1);
      bit_time_reg    <= '0;
      baud_locked_reg <= 1'h0;
    end else if (ce_in) begin
      if (state_reg == ST_BAUD) meas_cnt_reg <= meas_cnt_reg + MW'(1'h1);
      else meas_cnt_reg <= MW'(1'h1);
      if (err_any) begin
        baud_locked_reg <= 1'h0;  // R06
      end else if (state_reg == ST_BAUD && line_rise) begin
        bit_time_reg    <= meas_bits;  // R13
        baud_locked_reg <= (meas_bits != '0);
      end
    end
  end

  // ----------------------------------------
  // bit timer
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      bit_cnt_reg <= '0;
      bit_idx_reg <= DSL_BIT_START;
    end else if (ce_in) begin
      if (state_next != state_reg) begin
        bit_cnt_reg <= '0;
        bit_idx_reg <= DSL_BIT_START;
      end else if (at_end) begin
        bit_cnt_reg <= '0;
        bit_idx_reg <= bit_idx_reg + 4'h1;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + BAUD_W'(1'h1);
      end
    end
  end

  // ----------------------------------------
  // break and error detection
  // ----------------------------------------
  // low run saturates; the flag fires once on the last cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      low_cnt_reg <= '0;
      err_reg     <= '0;
      abort_reg   <= 1'h0;
    end else if (ce_in) begin
      if (line_high) low_cnt_reg <= '0;
      else if (low_cnt_reg < brk_limit) low_cnt_reg <= low_cnt_reg + LW'(1'h1);  // R01
      err_reg   <= '{brk: det_brk, frm: det_frm, col: det_col};
      abort_reg <= err_any;  // R04
    end
  end

  // returned break, measured in system clocks not bits
  always_ff @(posedge clk_in) begin
    if (reset_in) brk_cnt_reg <= '0;
    else if (ce_in) brk_cnt_reg <= (state_reg == ST_BREAK) ? brk_cnt_reg + BRK_W'(1'h1) : '0;  // R05
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  // lsb first, sampled at the bit centre
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_shift_reg <= '0;
      rx_data_reg  <= '0;
      rx_valid_reg <= 1'h0;
    end else if (ce_in) begin
      rx_valid_reg <= 1'h0;
      if (in_rx && at_center && !at_start && !at_stop) begin
        rx_shift_reg <= {line_high, rx_shift_reg[DSL_DATA_W-1:1]};
      end
      if (in_rx && at_center && at_stop && line_high) begin
        rx_data_reg  <= rx_shift_reg;
        rx_valid_reg <= 1'h1;
      end
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_frame_reg <= '1;
      prev_bit_reg <= 1'h1;
      hi_done_reg  <= 1'h0;
    end else if (ce_in) begin
      if (tx_pop) begin
        tx_frame_reg <= {1'h1, fifo_data, 1'h0};
        prev_bit_reg <= 1'h1;  // idle line is high
      end else if (in_tx && at_end) begin
        prev_bit_reg <= tx_bit;
      end
      // assist ends for the bit once the line is seen high
      if (tx_pop || at_end) hi_done_reg <= 1'h0;
      else if (in_tx && line_high) hi_done_reg <= 1'h1;  // R10
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // zeros are always pulled low; ones rely on the pull-up unless a mode helps
  always_comb begin
    drv_oe  = 1'h0;
    drv_val = 1'h1;
    if (state_reg == ST_BREAK) begin
      drv_oe  = 1'h1;  // R05
      drv_val = 1'h0;
    end else if (in_tx) begin
      if (!tx_bit) begin
        drv_oe  = 1'h1;
        drv_val = 1'h0;
      end else if (assist_pulse) begin
        drv_oe = (bit_cnt_reg == '0) && !prev_bit_reg;  // R11
      end else if (cfg_in.drive_both) begin
        drv_oe = !at_stop || before_center;  // R08 R09
      end else if (cfg_in.tx_drive_high_assist) begin
        // sensed level lags two clocks, so a short overdrive is possible
        drv_oe = !hi_done_reg && !line_high && before_center;  // R10
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_oe_reg  <= 1'h0;
      pin_out_reg <= 1'h1;
    end else if (ce_in) begin
      pin_oe_reg  <= drv_oe;
      pin_out_reg <= drv_val;
    end
  end

  // ----------------------------------------
  // send queue
  // ----------------------------------------
  // an error flushes queued characters along with the command
  dsl_fifo #(
    .WIDTH (DSL_DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .ce_in         (ce_in),
    .flush_in      (err_any),
    .in_data_in    (tx_data_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (tx_pop)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign debug_serial_pin_out    = pin_out_reg;
  assign debug_serial_pin_oe_out = pin_oe_reg;
  assign rx_data_out             = rx_data_reg;
  assign rx_valid_out            = rx_valid_reg;
  assign err_out                 = err_reg;
  assign cmd_abort_out           = abort_reg;
  assign baud_locked_out         = baud_locked_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  chk_break_span: assert property ($rose(err_reg.brk) |-> !$past(pin_s2_reg) // R01
    && ($past(low_cnt_reg) == $past(brk_limit) - LW'(1'h1))) else $error("break flagged early");
  chk_frame_stop: assert property ($rose(err_reg.frm) |-> $past(state_reg) == ST_RX // R02
    && $past(bit_idx_reg) == DSL_BIT_STOP && !$past(pin_s2_reg)) else $error("bad framing flag");
  chk_collide_seen: assert property ($rose(err_reg.col) |-> $past(state_reg) == ST_TX // R03
    && $past(tx_bit) && !$past(pin_s2_reg)) else $error("bad collision flag");
  chk_abort_error: assert property ((ce_in && err_any) |=> abort_reg // R04
    && state_reg == ST_BREAK) else $error("error did not abort");
  chk_break_end: assert property ((ce_in && state_reg == ST_BREAK && brk_last) |=> // R05
    state_reg != ST_BREAK && pin_oe_reg && !pin_out_reg) else $error("break length wrong");
  chk_break_low: assert property ((state_reg == ST_BREAK && brk_cnt_reg != '0) |-> // R05
    pin_oe_reg && !pin_out_reg) else $error("break not low");
  chk_baud_cleared: assert property (state_reg == ST_BREAK |-> !baud_locked_reg) // R06
    else $error("baud kept through recovery");
  chk_both_drive: assert property ((ce_in && in_tx && cfg_in.drive_both // R08
    && !cfg_in.tx_drive_high_assist && tx_bit && !at_stop) |=> pin_oe_reg && pin_out_reg)
    else $error("drive-both not driving high");
  chk_stop_release: assert property ((ce_in && in_tx && cfg_in.drive_both && at_stop // R09
    && !before_center) |=> !pin_oe_reg) else $error("drive past stop centre");
  chk_assist_stop: assert property ((ce_in && in_tx && line_high // R10
    && !cfg_in.drive_both) |=> !(pin_oe_reg && pin_out_reg)) else $error("assist after high");
  chk_assist_pulse: assert property ((ce_in && pin_oe_reg && pin_out_reg && assist_pulse) // R11
    |=> !(pin_oe_reg && pin_out_reg) || !assist_pulse) else $error("assist pulse too long");
  chk_baud_rate: assert property ($rose(baud_locked_reg) |-> // R13
    bit_time_reg == $past(meas_bits)) else $error("rate not from sync");

endmodule
`default_nettype wire

// File: tb/dsl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// debug host adapter on the single wire
// ----------------------------------------
module dsl_host_model #(
  parameter int BIT_CYC = 8  // host bit time in system clocks
) (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      pull_low_out
);
  logic [7:0] rx_q[$];  // characters heard from the device

  initial begin
    pull_low_out = 1'b0;  // open drain: released means pulled up
  end

  // sync char: eight bit times low sets the device bit rate
  task automatic send_sync();
    @(posedge clk_in);
    pull_low_out <= 1'b1;
    repeat (8 * BIT_CYC) @(posedge clk_in);
    pull_low_out <= 1'b0;
  endtask

  // one 8N1 frame, lsb first; a low stop bit fakes a framing fault
  task automatic send_char(input logic [7:0] data, input logic stop);
    logic [9:0] frame;
    frame = {stop, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      pull_low_out <= ~frame[i];
      repeat (BIT_CYC - 1) @(posedge clk_in);
    end
    @(posedge clk_in);
    pull_low_out <= 1'b0;
  endtask

  // line held low on purpose to force recovery
  task automatic send_break(input int bits);
    @(posedge clk_in);
    pull_low_out <= 1'b1;
    repeat (bits * BIT_CYC) @(posedge clk_in);
    pull_low_out <= 1'b0;
  endtask

  // receiver samples device frames at bit centres; deaf while pulling
  initial begin
    logic [7:0] d;
    d = 8'h00;
    forever begin
      @(posedge clk_in);
      if (!line_in && !pull_low_out) begin
        repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
          d[i] = line_in;
          repeat (BIT_CYC) @(posedge clk_in);
        end
        rx_q.push_back(d);
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_dsl_link.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dsl_link;
  import dsl_pkg::*;
  // ----------------------------------------
  // bench signals
  // ----------------------------------------
  localparam int B   = 8;   // host bit time in clocks
  localparam int BRK = 16;  // shortened returned break
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        tx_valid = 1'b0;
  logic [7:0]  tx_data = 8'h00;
  dsl_cfg_type cfg = '0;
  logic        pin_out, pin_oe, tx_ready, rx_valid, abort, locked, host_low;
  logic [7:0]  rx_data;
  dsl_err_type err;
  wire         line = (pin_oe ? pin_out : 1'b1) & ~host_low;  // pull-up and of drivers
  int n_errors = 0, n_checks = 0;
  int rx_cnt = 0, frm_cnt = 0, col_cnt = 0, brk_cnt = 0, ab_cnt = 0, oe_cnt = 0, low_cnt = 0;
  logic [7:0]  rx_seen = 8'h00;

  dsl_link #(.BREAK_TX_CYCLES(BRK)) i_dsl_link (
    .clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1), .debug_serial_pin_in(line),
    .debug_serial_pin_out(pin_out), .debug_serial_pin_oe_out(pin_oe), .cfg_in(cfg),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .rx_data_out(rx_data),
    .rx_valid_out(rx_valid), .err_out(err), .cmd_abort_out(abort), .baud_locked_out(locked));
  dsl_host_model #(.BIT_CYC(B)) i_dsl_host_model (
    .clk_in(clk_in), .line_in(line), .pull_low_out(host_low));

  initial forever #2.5 clk_in = ~clk_in;

  // event counters; scenarios compare differences, so nothing is cleared
  always @(posedge clk_in) begin
    if (rx_valid) begin
      rx_cnt++;
      rx_seen = rx_data;
    end
    if (err.frm) frm_cnt++;
    if (err.col) col_cnt++;
    if (err.brk) brk_cnt++;
    if (abort) ab_cnt++;
    if (pin_oe) oe_cnt++;
    if (pin_oe && !pin_out) low_cnt++;
  end

  // ----------------------------------------
  // compare and closing
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // offer one byte and hold it until the fifo takes it
  task automatic push(input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    tx_data <= d;
    tx_valid <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
    end while (tx_ready !== 1'b1 && k < 50);
    tx_valid <= 1'b0;
    if (k >= 50) check(16'h0, 16'h1);
  endtask

  task automatic sync();
    i_dsl_host_model.send_sync();
    repeat (2 * B) @(posedge clk_in);
    check(locked, 1'b1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // fifo filled while the host stalls unsynced, then drained by the link
  task automatic fill_and_drain();
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      tx_data <= 8'(8'h11 * (i + 1));
      tx_valid <= 1'b1;
    end
    repeat (2) @(posedge clk_in);
    tx_valid <= 1'b0;
    #1 check(tx_ready, 1'b0);
    sync();
    repeat (4 * 12 * B) @(posedge clk_in);
    check(i_dsl_host_model.rx_q.size(), 4);
    for (int i = 0; i < 4; i++) check(i_dsl_host_model.rx_q[i], 8'(8'h11 * (i + 1)));
  endtask

  // two characters back to back at the measured rate
  task automatic rx_chars();
    int r0, f0;
    r0 = rx_cnt;
    f0 = frm_cnt;
    i_dsl_host_model.send_char(8'hA5, 1'b1);
    i_dsl_host_model.send_char(8'h5A, 1'b1);
    repeat (2 * B) @(posedge clk_in);
    check(16'(rx_cnt - r0), 16'h2);
    check(rx_seen, 8'h5A);
    check(16'(frm_cnt - f0), 16'h0);
  endtask

  // drive-enable cycles of one 0x55 frame under a given mode
  task automatic drive_mode(input dsl_cfg_type c, input int lo, input int hi);
    int o0, d;
    @(posedge clk_in);
    cfg <= c;
    i_dsl_host_model.rx_q.delete();
    o0 = oe_cnt;
    push(8'h55);
    repeat (14 * B) @(posedge clk_in);
    d = oe_cnt - o0;
    if (lo == hi) check(16'(d), 16'(lo));
    else check(16'(d >= lo && d <= hi), 16'h1);
    check(i_dsl_host_model.rx_q[0], 8'h55);
  endtask

  // fault recovery: abort pulse, returned break length, unlock, resync
  task automatic recovered(input int a0, input int l0);
    repeat (6 * B) @(posedge clk_in);
    check(16'(ab_cnt - a0), 16'h1);
    check(16'(low_cnt - l0), 16'(BRK));
    check(locked, 1'b0);
    i_dsl_host_model.rx_q.delete();
    sync();
  endtask

  // host pulls low during a device frame: a short pull in a one bit collides,
  // a long pull just past the stop centre is seen as a break
  task automatic tx_fault(input logic [7:0] d, input int w, input int bits, input int col, input int brk);
    int c0, b0, a0, l0, k;
    k = 0;
    cfg <= '0;
    push(d);
    while (pin_oe !== 1'b1 && k < 100) begin
      @(posedge clk_in);
      k++;
    end
    check(16'(k < 100), 16'h1);
    repeat (w) @(posedge clk_in);
    c0 = col_cnt;
    b0 = brk_cnt;
    a0 = ab_cnt;
    l0 = low_cnt;
    i_dsl_host_model.send_break(bits);
    recovered(a0, l0);
    check(16'(col_cnt - c0), 16'(col));
    check(16'(brk_cnt - b0), 16'(brk));
  endtask

  task automatic framing();
    int f0, a0, l0;
    f0 = frm_cnt;
    a0 = ab_cnt;
    l0 = low_cnt;
    i_dsl_host_model.send_char(8'h3C, 1'b0);
    recovered(a0, l0);
    check(16'(frm_cnt - f0), 16'h1);
  endtask

  task automatic host_break();
    int e0, a0, l0;
    e0 = frm_cnt + col_cnt + brk_cnt;
    a0 = ab_cnt;
    l0 = low_cnt;
    i_dsl_host_model.send_break(12);
    recovered(a0, l0);
    check(16'(frm_cnt + col_cnt + brk_cnt - e0 > 0), 16'h1);
  endtask

  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    #1 check({pin_oe, locked, tx_ready}, 3'b001);
    fill_and_drain();
    rx_chars();
    drive_mode(2'b00, 5 * B, 5 * B);
    drive_mode(2'b10, 9 * B + B / 2, 9 * B + B / 2);
    drive_mode(2'b01, 5 * B + 1, 9 * B + B / 2 - 1);
    drive_mode(2'b11, 5 * B + 5, 5 * B + 5);
    tx_fault(8'hFF, 2 * B, 1, 1, 0);
    tx_fault(8'h00, 9 * B + 1, 12, 0, 1);
    framing();
    host_break();
    end_sim();
  end

  initial begin
    #400000;
    check(16'h0, 16'h1);
    end_sim();
  end
endmodule
`default_nettype wire
